// File: design/ast_defines.vh
// Purpose: constants for the asynchronous serial transmitter
// Assumes: 100 MHz system clock, registers reached over a plain strobe port
// Notes: offsets are word indices on the register port
`ifndef AST_DEFINES_VH
`define AST_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AST_ADDR_W 3
`define AST_OFF_STATUS 3'h0
`define AST_OFF_DATA 3'h1
`define AST_OFF_CTRL 3'h2
`define AST_OFF_BAUD 3'h3
`define AST_OFF_ETPR 3'h4

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define AST_CTRL_TX_ON 0
`define AST_CTRL_RX_ON 1
`define AST_CTRL_WORD9 2
`define AST_CTRL_NINTH 3
`define AST_CTRL_BREAK 4
`define AST_CTRL_TIE 5
`define AST_CTRL_TX_COMPLETE_IRQ_ENABLE 6
`define AST_CTRL_IMASK 7

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define AST_STAT_TX_BUFFER_EMPTY_FLAG 7
`define AST_STAT_TC 6
`define AST_STAT_BUSY 0

// ----------------------------------------------------------------------
// Baud register fields: prescaler select [5:4], power-of-two [2:0]
// ----------------------------------------------------------------------
`define AST_BAUD_PR_HI 5
`define AST_BAUD_PR_LO 4
`define AST_BAUD_TR_HI 2
`define AST_BAUD_TR_LO 0

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define AST_CTRL_RST 8'h00
`define AST_BAUD_RST 8'h00
`define AST_ETPR_RST 8'h00
`define AST_OVERSAMPLE 16
`define AST_CLK_MHZ 100
`define AST_MAX_BAUD 500000

`endif

// File: design/ast_baud_gen.v
// Purpose: transmit bit-rate tick generator
// Assumes: settings held steady while the transmitter runs
// Notes: one-cycle tick per bit period
`timescale 1ns/1ps
`include "ast_defines.vh"

module ast_baud_gen #(
  parameter CNT_W = 12
) (
  input wire sys_clk,
  input wire rstn,
  input wire run,
  input wire [1:0] pr_sel,
  input wire [2:0] tr_sel,
  input wire [7:0] etpr,
  output reg bit_tick
);

  // ----------------------------------------------------------------------
  // Prescaler decode
  // ----------------------------------------------------------------------
  reg [3:0] pr_max;
  always @* begin
    case (pr_sel)
      2'h0: pr_max = 4'h0;
      2'h1: pr_max = 4'h2;
      2'h2: pr_max = 4'h3;
      default: pr_max = 4'hC;
    endcase
  end

  reg [3:0] os_q;
  reg [3:0] pr_q;
  reg [6:0] tr_q;
  reg [7:0] et_q;
  wire os_end = (os_q == 4'hF);
  wire pr_end = os_end && (pr_q == pr_max);
  wire [6:0] tr_max = (7'h01 << tr_sel) - 7'h01;
  wire tr_end = pr_end && (tr_q == tr_max);
  // Zero leaves the extended stage transparent
  wire [7:0] et_max = (etpr == 8'h00) ? 8'h00 : etpr - 8'h01;
  wire et_end = tr_end && (et_q == et_max);

  // Cascade of divide-by-16, PR, TR and extended stage
  always @(posedge sys_clk) begin
    if (!rstn || !run) begin
      os_q <= 4'h1; // Head start pays for the registered tick
      pr_q <= 4'h0;
      tr_q <= 7'h00;
      et_q <= 8'h00;
      bit_tick <= 1'b0;
    end else begin
      os_q <= os_q + 4'h1;
      if (os_end)
        pr_q <= (pr_q == pr_max) ? 4'h0 : pr_q + 4'h1;
      if (pr_end)
        tr_q <= (tr_q == tr_max) ? 7'h00 : tr_q + 7'h01;
      if (tr_end)
        et_q <= (et_q == et_max) ? 8'h00 : et_q + 8'h01;
      bit_tick <= et_end;
    end
  end

endmodule // ast_baud_gen

// File: design/ast_tx.v
// Purpose: transmit half of an asynchronous NRZ serial interface
// Assumes: inputs synchronous to sys_clk; interrupt masking is a control bit
// Notes: registers on a plain strobe port, read data one cycle after the strobe
`timescale 1ns/1ps
`include "ast_defines.vh"

module ast_tx #(
  parameter BAUD_CNT_W = 12
) (
  input wire sys_clk,
  input wire rstn,
  input wire [`AST_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire tx_serial_out,
  output wire tx_serial_oe,
  output wire irq_req
);

  // ----------------------------------------------------------------------
  // Frame sequencer states
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_PREAMBLE = 3'h4;
  localparam ST_BRK_END = 3'h5;

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg [7:0] baud_q;
  reg [7:0] etpr_q;
  reg [8:0] hold_q;
  reg hold_full_q;
  reg tx_buffer_empty_flag_q;
  reg tc_q;
  reg stat_seen_q;

  wire tx_on = ctrl_q[`AST_CTRL_TX_ON];
  wire rx_on = ctrl_q[`AST_CTRL_RX_ON];
  wire word9 = ctrl_q[`AST_CTRL_WORD9];
  wire ninth = ctrl_q[`AST_CTRL_NINTH];
  wire send_break = ctrl_q[`AST_CTRL_BREAK];
  wire tx_empty_irq_enable = ctrl_q[`AST_CTRL_TIE];
  wire tx_complete_irq_enable = ctrl_q[`AST_CTRL_TX_COMPLETE_IRQ_ENABLE];
  wire imask = ctrl_q[`AST_CTRL_IMASK];

  wire wr_data = reg_wr && (reg_addr == `AST_OFF_DATA);
  wire wr_ctrl = reg_wr && (reg_addr == `AST_OFF_CTRL);
  wire rd_stat = reg_rd && (reg_addr == `AST_OFF_STATUS);
  // Only a data write right after a status read counts as the clear sequence
  wire clr_seq = wr_data && stat_seen_q;

  // ----------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------
  reg [2:0] state_q;
  reg [8:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg line_q;
  reg is_break_q;
  reg idle_pend_q;
  wire bit_tick;

  // Frame length in bits: start + data + stop
  wire [3:0] data_bits = word9 ? 4'h9 : 4'h8;
  wire [3:0] frame_bits = data_bits + 4'h2;

  // Word with ninth bit merged in as MSB
  wire [8:0] load_word = {word9 ? ninth : 1'b0, reg_wdata};

  // Tx_on rising edge detection for idle insertion
  reg tx_on_prev_q;
  wire tx_on_rise = tx_on && !tx_on_prev_q;

  // ----------------------------------------------------------------------
  // Bit-rate generator
  // ----------------------------------------------------------------------
  // Held in reset while idle, so the first slot of a frame is a whole period;
  // a free-running divider would clip the start bit of a directly written word
  ast_baud_gen #(
    .CNT_W(BAUD_CNT_W)
  ) u_baud (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(state_q != ST_IDLE),
    .pr_sel(baud_q[`AST_BAUD_PR_HI:`AST_BAUD_PR_LO]),
    .tr_sel(baud_q[`AST_BAUD_TR_HI:`AST_BAUD_TR_LO]),
    .etpr(etpr_q),
    .bit_tick(bit_tick)
  );

  // ----------------------------------------------------------------------
  // Frame boundary decisions
  // ----------------------------------------------------------------------
  wire frame_end = bit_tick && (state_q == ST_STOP ||
    state_q == ST_PREAMBLE || state_q == ST_BRK_END) &&
    (bit_cnt_q == 4'h0);
  wire is_idle = (state_q == ST_IDLE);
  // Direct load only when nothing in flight; a write in the cycle that
  // enables the line waits behind the idle frame instead of being lost
  wire direct_load = wr_data && is_idle && tx_on && !idle_pend_q &&
    !tx_on_rise && !send_break;
  // Slots where the sequencer may start the held word: a data stop bit,
  // the mark after a break, or the last slot of an idle frame; flags and
  // sequencer share this term so only an enable toggle drops a word unsent
  wire hold_slot = (state_q == ST_STOP && !is_break_q) || state_q == ST_BRK_END ||
    (state_q == ST_PREAMBLE && bit_cnt_q == 4'h0);
  wire take_hold = bit_tick && hold_slot && hold_full_q && tx_on && !send_break &&
    !idle_pend_q;

  // ----------------------------------------------------------------------
  // Control, baud and holding registers; flags
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q <= `AST_CTRL_RST;
      baud_q <= `AST_BAUD_RST;
      etpr_q <= `AST_ETPR_RST;
      hold_q <= 9'h000;
      hold_full_q <= 1'b0;
      tx_buffer_empty_flag_q <= 1'b1;
      tc_q <= 1'b1;
      stat_seen_q <= 1'b0;
      tx_on_prev_q <= 1'b0;
    end else begin
      tx_on_prev_q <= tx_on;
      // Any other access breaks the status-then-data sequence
      if (rd_stat)
        stat_seen_q <= 1'b1;
      else if (reg_rd || reg_wr)
        stat_seen_q <= 1'b0;
      if (wr_ctrl)
        ctrl_q <= reg_wdata;
      // Rates are latched blindly; software keeps them still while enabled
      if (reg_wr && reg_addr == `AST_OFF_BAUD)
        baud_q <= reg_wdata;
      if (reg_wr && reg_addr == `AST_OFF_ETPR)
        etpr_q <= reg_wdata;
      // Holding buffer: written while busy, dropped on enable toggle
      if (wr_data && !direct_load && tx_on) begin
        hold_q <= load_word;
        hold_full_q <= 1'b1;
      end else if (tx_on_rise && !is_idle) begin
        hold_full_q <= 1'b0;
      end else if (take_hold) begin
        hold_full_q <= 1'b0;
      end
      // Buffer-empty sets where the held word starts, not when it is written
      // Set wins over clear: set terms are placed last
      if (clr_seq)
        tx_buffer_empty_flag_q <= 1'b0;
      if (direct_load)
        tx_buffer_empty_flag_q <= 1'b1;
      if (take_hold)
        tx_buffer_empty_flag_q <= 1'b1;
      if (tx_on_rise && !is_idle)
        tx_buffer_empty_flag_q <= 1'b1;
      if (clr_seq)
        tc_q <= 1'b0;
      if (frame_end && state_q == ST_STOP)
        tc_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      shift_q <= 9'h1FF;
      bit_cnt_q <= 4'h0;
      line_q <= 1'b1;
      is_break_q <= 1'b0;
      idle_pend_q <= 1'b0;
    end else begin
      // Every slot ends on a bit tick, so each lasts one whole bit period
      // Enable edge queues a preamble frame
      if (tx_on_rise)
        idle_pend_q <= 1'b1;
      case (state_q)
        ST_IDLE: begin
          line_q <= 1'b1;
          is_break_q <= 1'b0;
          // Idle frame first, then break, then a directly written word
          if (tx_on && (idle_pend_q || tx_on_rise)) begin
            state_q <= ST_PREAMBLE;
            bit_cnt_q <= frame_bits - 4'h1;
            idle_pend_q <= 1'b0;
          end else if (tx_on && send_break) begin
            state_q <= ST_START;
            shift_q <= 9'h000;
            is_break_q <= 1'b1;
            line_q <= 1'b0;
            bit_cnt_q <= 4'h0;
          end else if (direct_load) begin
            state_q <= ST_START;
            shift_q <= load_word;
            line_q <= 1'b0;
            bit_cnt_q <= 4'h0;
          end
        end
        ST_START: begin
          if (bit_tick) begin
            // Start slot over: first data bit goes out
            state_q <= ST_DATA;
            line_q <= shift_q[0];
            shift_q <= {1'b1, shift_q[8:1]};
            bit_cnt_q <= data_bits - 4'h1;
          end
        end
        ST_DATA: begin
          if (bit_tick) begin
            // Zero count: the last data bit has had its full slot
            if (bit_cnt_q == 4'h0) begin
              // Break frames keep the line low through the stop slot
              state_q <= ST_STOP;
              line_q <= is_break_q ? 1'b0 : 1'b1;
              bit_cnt_q <= 4'h0;
            end else begin
              line_q <= shift_q[0];
              shift_q <= {1'b1, shift_q[8:1]};
              bit_cnt_q <= bit_cnt_q - 4'h1;
            end
          end
        end
        ST_PREAMBLE: begin
          line_q <= 1'b1;
          if (bit_tick) begin
            // Last idle slot hands over to a word queued meanwhile
            if (bit_cnt_q != 4'h0)
              bit_cnt_q <= bit_cnt_q - 4'h1;
            else if (take_hold) begin
              state_q <= ST_START;
              shift_q <= hold_q;
              line_q <= 1'b0;
            end else
              state_q <= ST_IDLE;
          end
        end
        ST_BRK_END: begin
          line_q <= 1'b1;
          if (bit_tick) begin
            if (take_hold) begin
              state_q <= ST_START;
              shift_q <= hold_q;
              line_q <= 1'b0;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_STOP: begin
          if (bit_tick) begin
            if (is_break_q && !send_break) begin
              state_q <= ST_BRK_END;
              line_q <= 1'b1;
              is_break_q <= 1'b0;
            end else if (!tx_on || idle_pend_q) begin
              state_q <= ST_IDLE;
              line_q <= 1'b1;
              is_break_q <= 1'b0;
            end else if (send_break) begin
              state_q <= ST_START;
              shift_q <= 9'h000;
              is_break_q <= 1'b1;
              line_q <= 1'b0;
            end else if (hold_full_q) begin
              state_q <= ST_START;
              shift_q <= hold_q;
              line_q <= 1'b0;
            end else begin
              state_q <= ST_IDLE;
              line_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          line_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin and interrupt outputs
  // ----------------------------------------------------------------------
  // Released to the port logic only when both directions are off
  assign tx_serial_oe = tx_on || rx_on || !is_idle;
  // Line comes from a flop, so decode glitches never reach the pin
  assign tx_serial_out = line_q;
  assign irq_req = !imask && ((tx_empty_irq_enable && tx_buffer_empty_flag_q) || (tx_complete_irq_enable && tc_q));

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  // Read data stand one cycle after the strobe and are zero otherwise
  always @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `AST_OFF_STATUS: reg_rdata <= {tx_buffer_empty_flag_q, tc_q, 5'h00, !is_idle};
        `AST_OFF_CTRL: reg_rdata <= ctrl_q;
        `AST_OFF_BAUD: reg_rdata <= baud_q;
        `AST_OFF_ETPR: reg_rdata <= etpr_q;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // ast_tx

// File: tb/ast_tx_assertions.sv
// Purpose: port-level checks for the serial transmitter
// Assumes: bit periods of at least 16 clocks
// Notes: control bits are shadowed from register writes
`timescale 1ns/1ps
`include "ast_defines.vh"
module ast_tx_assertions (
  input wire sys_clk,
  input wire rstn,
  input wire [`AST_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire tx_serial_out,
  input wire tx_serial_oe,
  input wire irq_req
);
  logic [7:0] ctrl_q;
  // Shadow of the control register, so enables and masks are known here
  always @(posedge sys_clk) begin
    if (!rstn)
      ctrl_q <= 8'h00;
    else if (reg_wr && reg_addr == `AST_OFF_CTRL)
      ctrl_q <= reg_wdata;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ------------------------
  // Bus steps
  // ------------------------
  sequence s_stat_rd;
    reg_rd && reg_addr == `AST_OFF_STATUS;
  endsequence
  sequence s_data_wr;
    reg_wr && reg_addr == `AST_OFF_DATA && ctrl_q[0];
  endsequence
  AST_OE_ON: assert property (ctrl_q[0] |-> tx_serial_oe)
    else $error("pin not owned while enabled");
  AST_PRE_HIGH: assert property ($rose(ctrl_q[0]) && !$past(tx_serial_oe) |-> tx_serial_out [*8])
    else $error("idle frame not high");
  AST_BIT_HOLD: assert property (disable iff (!rstn || !ctrl_q[0])
    $changed(tx_serial_out) |=> $stable(tx_serial_out) [*8])
    else $error("bit shorter than a period");
  AST_TX_BUFFER_EMPTY_FLAG_IRQ: assert property ($past(reg_rd && reg_addr == `AST_OFF_STATUS) && reg_rdata[7]
    && ctrl_q[5] && !ctrl_q[7] |-> irq_req)
    else $error("empty interrupt missing");
  AST_TC_IRQ: assert property ($past(reg_rd && reg_addr == `AST_OFF_STATUS) && reg_rdata[6]
    && ctrl_q[6] && !ctrl_q[7] |-> irq_req)
    else $error("complete interrupt missing");
  AST_IRQ_OFF: assert property (ctrl_q[7] || !(ctrl_q[5] || ctrl_q[6]) |-> !irq_req)
    else $error("interrupt while masked");
  AST_TC_CLR: assert property (s_stat_rd ##2 s_data_wr ##2 s_stat_rd |=> !reg_rdata[6])
    else $error("complete flag not cleared");
  AST_BRK_LOW: assert property ($rose(ctrl_q[4]) && ctrl_q[0] |-> ##[1:400] !tx_serial_out)
    else $error("no break frame");
  AST_BRK_MARK: assert property ($fell(ctrl_q[4]) && ctrl_q[0] |-> ##[1:400] tx_serial_out)
    else $error("no mark after break");
endmodule // ast_tx_assertions

// File: tb/ast_line_monitor.sv
// Purpose: far-end receiver decoding frames off the serial line
// Assumes: bit period in clocks given by the bench
// Notes: after a low stop slot it waits for the line to recover
`timescale 1ns/1ps
module ast_line_monitor (
  input wire sys_clk,
  input wire rx_serial_in,
  input wire word9,
  input wire [15:0] bit_clks,
  output logic rx_valid,
  output logic [9:0] rx_frame
);
  int i;
  int n;
  // Start edge, then mid-bit samples; frame is {stop, word}
  initial begin
    rx_valid = 1'b0;
    rx_frame = 10'h000;
    forever begin
      @(negedge rx_serial_in);
      n = word9 ? 9 : 8;
      rx_frame = 10'h000;
      repeat (bit_clks / 2) @(posedge sys_clk);
      for (i = 0; i <= n; i++) begin
        repeat (bit_clks) @(posedge sys_clk);
        rx_frame[(i == n) ? 9 : i] = rx_serial_in;
      end
      @(negedge sys_clk);
      rx_valid = 1'b1;
      @(negedge sys_clk);
      rx_valid = 1'b0;
      if (!rx_frame[9])
        wait (rx_serial_in === 1'b1);
    end
  end
endmodule // ast_line_monitor

// File: tb/testbench.sv
// Purpose: self-checking bench for the serial transmitter
// Assumes: read data one cycle after the strobe
// Notes: a frame queue predicts every frame the far end decodes
`timescale 1ns/1ps
`include "ast_defines.vh"
module testbench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire tx_serial_out;
  wire tx_serial_oe;
  wire irq_req;
  wire line;
  wire rx_valid;
  wire [9:0] rx_frame;
  logic word9 = 1'b0;
  logic [15:0] bit_clks = 16'h0010;
  logic [7:0] st;
  logic [7:0] b;
  logic [7:0] ic [4] = '{8'h21, 8'h41, 8'hE1, 8'h01};
  int iq [4] = '{1, 1, 0, 0};
  int bd [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h02, 8'h00};
  int et [6] = '{0, 0, 0, 0, 0, 3};
  int pd [6] = '{16, 48, 64, 208, 64, 48};
  int fails = 0;
  int total_checks = 0;
  int low_n = 0;
  int last_low = 0;
  int exp_q [$];
  int i;
  int k;
  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // Released pin sits at its pull-up level
  assign line = tx_serial_oe ? tx_serial_out : 1'b1;
  ast_tx uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_serial_out(tx_serial_out),
    .tx_serial_oe(tx_serial_oe), .irq_req(irq_req));
  ast_line_monitor far (.sys_clk(sys_clk), .rx_serial_in(line), .word9(word9),
    .bit_clks(bit_clks), .rx_valid(rx_valid), .rx_frame(rx_frame));
  task automatic check(input string what, input logic [15:0] seen, input int exp);
    total_checks++;
    if (seen !== exp[15:0]) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp[15:0], seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Strobes get a quiet cycle after them, so no signal is driven twice per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic send(input logic [7:0] d, input int frame);
    rd(`AST_OFF_STATUS, st);
    wr(`AST_OFF_DATA, d);
    if (frame >= 0)
      exp_q.push_back(frame);
  endtask
  task automatic give_up;
    fails++;
    finish_test;
  endtask
  task automatic wait_idle;
    st = 8'h00;
    // Complete flag rises after every data or break frame; busy low means the queue ran dry
    for (k = 0; k < 3000 &&
      (st[`AST_STAT_TC] !== 1'b1 || st[`AST_STAT_BUSY] !== 1'b0); k++)
      rd(`AST_OFF_STATUS, st);
    if (k == 3000)
      give_up;
  endtask
  task automatic wait_line(input logic v);
    for (k = 0; k < 5000 && tx_serial_out !== v; k++)
      @(posedge sys_clk);
    if (k == 5000)
      give_up;
  endtask
  // Length of the latest low run on the line
  always @(posedge sys_clk) begin
    if (tx_serial_out === 1'b0)
      low_n <= low_n + 1;
    else if (low_n != 0) begin
      last_low <= low_n;
      low_n <= 0;
    end
  end
  // Far-end frames against the predicted queue
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("rx_extra", 16'h0001, 0);
      else
        check("rx_frame", {6'h00, rx_frame}, exp_q.pop_front());
    end
  end
  // Main sequence
  initial begin
    void'($urandom(13));
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(`AST_OFF_STATUS, st);
    check("status", st, 8'hC0);
    rd(3'h7, st);
    check("unmapped", st, 0);
    check("oe", tx_serial_oe, 0);
    wr(`AST_OFF_CTRL, 8'h02);
    check("oe_rx", tx_serial_oe, 1);
    check("line_rx", tx_serial_out, 1);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wr(`AST_OFF_CTRL, ic[i]);
      rd(`AST_OFF_STATUS, st);
      check("irq", irq_req, iq[i]);
    end
    $display("test irq done");
    repeat (200) @(posedge sys_clk);
    b = $urandom;
    send(b, {2'b10, b});
    check("start", tx_serial_out, 0);
    rd(`AST_OFF_STATUS, st);
    check("flags", st[7:6], 2'b10);
    b = $urandom;
    send(b, {2'b10, b});
    rd(`AST_OFF_STATUS, st);
    check("tx_buffer_empty_flag", st[7], 0);
    wait_idle;
    check("drained", exp_q.size(), 0);
    $display("test buffer done");
    for (i = 0; i < 2; i++) begin
      word9 = 1'b1;
      wr(`AST_OFF_CTRL, i ? 8'h0D : 8'h05);
      b = $urandom;
      send(b, {1'b1, i[0], b});
      wait_idle;
    end
    word9 = 1'b0;
    wr(`AST_OFF_CTRL, 8'h01);
    $display("test ninth bit done");
    exp_q.push_back(0);
    wr(`AST_OFF_CTRL, 8'h11);
    repeat (250) @(posedge sys_clk);
    wr(`AST_OFF_CTRL, 8'h01);
    wait_line(1'b1);
    repeat (20) @(posedge sys_clk);
    check("break_len", last_low % 160, 0);
    check("break_frames", last_low / 160, 2);
    b = $urandom;
    send(b, {2'b10, b});
    wait_idle;
    $display("test break done");
    b = $urandom;
    send(b, {2'b10, b});
    send(~b, -1);
    wr(`AST_OFF_CTRL, 8'h00);
    wr(`AST_OFF_CTRL, 8'h01);
    wait_idle;
    repeat (400) @(posedge sys_clk);
    check("dropped", exp_q.size(), 0);
    $display("test toggle done");
    for (i = 0; i < 6; i++) begin
      wr(`AST_OFF_CTRL, 8'h00);
      wr(`AST_OFF_BAUD, bd[i][7:0]);
      wr(`AST_OFF_ETPR, et[i][7:0]);
      bit_clks = pd[i][15:0];
      wr(`AST_OFF_CTRL, 8'h01);
      repeat (11 * pd[i]) @(posedge sys_clk);
      send(8'hFF, 10'h2FF);
      wait_idle;
      check("bit_len", last_low, pd[i]);
    end
    $display("test baud done");
    finish_test;
  end
endmodule // testbench
bind ast_tx ast_tx_assertions chk (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_serial_out(tx_serial_out), .tx_serial_oe(tx_serial_oe), .irq_req(irq_req));
